// File: src/pdh_keep_if.sv
// Carrier between the power-down controller and its input keeper bank
`timescale 1ns/100ps
interface pdh_keep_if #(
    parameter int W = 1
);
    logic hold;
    logic [W-1:0] d;
    logic [W-1:0] q;

    modport keeper (
        input hold,
        input d,
        output q
    );
    modport ctrl (
        output hold,
        output d,
        input q
    );
endinterface

// File: src/pdh_keeper.sv
// Input and bidirectional pin keeper bank with blocking hold
`timescale 1ns/100ps
module pdh_keeper
    import pdh_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Keeper port
    pdh_keep_if.keeper kp
);
    typedef struct packed {
        logic [W-1:0] lvl;
    } pdh_keep_st_t;

    pdh_keep_st_t r_r;
    pdh_keep_st_t r_nxt;

    // ****************************************
    // Per-pin latch
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            // While held the pin level is frozen, so no pin can disturb the core
            always_comb begin
                r_nxt.lvl[gi] = kp.hold ? r_r.lvl[gi] : kp.d[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_r.lvl <= {W{RST_BIT}};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign kp.q = r_r.lvl;

    property p_keep_hold;
        @(posedge clk) disable iff (rst)
        kp.hold |=> $stable(kp.q);
    endproperty
    a_keep_hold: assert property (p_keep_hold) else $error("keeper level moved while held");
endmodule

// File: src/pdh_pkg.sv
// Shared constants and types for the pin-controlled power-down hold block
package pdh_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    // Longest settle window after the sleep pin falls; rounds down
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC_RAW = SETTLE_NS / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_RUN = 1'h1;
    localparam logic RST_SETTLED = 1'h1;
    localparam logic RST_BIT = 1'h0;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {
        PDH_RUN,
        PDH_SLEEP,
        PDH_SETTLE
    } pdh_state_t;
endpackage

// File: src/pdh_top.sv
// Pin-controlled power-down hold: freezes core, outputs and input pins on sleep
`timescale 1ns/100ps
module pdh_top
    import pdh_pkg::*;
#(
    parameter int N_IN = 4,
    parameter int N_IO = 32,
    parameter bit PD_ENABLE = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Power-down request
    input wire logic sleep_request_pin,
    // Pins
    input wire logic [N_IN-1:0] in_pin,
    input wire logic [N_IO-1:0] io_i,
    output logic [N_IO-1:0] io_o,
    output logic [N_IO-1:0] io_oe,
    output logic [N_IO-1:0] io_keep_o,
    output logic [N_IO-1:0] io_keep_oe,
    // Core side
    input wire logic [N_IO-1:0] core_out,
    input wire logic [N_IO-1:0] core_oe,
    input wire logic sleep_mc_d,
    output logic [N_IN+N_IO-1:0] core_in,
    output logic core_run,
    output logic sleep_mc_fb,
    output logic out_settled
);
    localparam int NK = N_IN + N_IO;
    localparam int SETTLE_LIM = SETTLE_CYC + 2;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    generate
        if (N_IN < 1 || N_IO < 1) begin : g_bad
            $error("pdh_top needs at least one input pin and one I/O pin");
        end
    endgenerate

    typedef struct packed {
        pdh_state_t st;
        logic [CNT_W-1:0] cnt;
        logic run;
        logic settled;
        logic [N_IO-1:0] pad_o;
        logic [N_IO-1:0] pad_oe;
        logic [N_IO-1:0] keep_oe;
        logic mc_fb;
    } pdh_top_st_t;

    pdh_top_st_t r_r;
    pdh_top_st_t r_nxt;
    logic sleep_active;

    pdh_keep_if #(.W(NK)) kif ();

    // ****************************************
    // Sleep request qualification
    // ****************************************
    // With the feature left out the pin is never looked at
    assign sleep_active = PD_ENABLE && sleep_request_pin;

    // ****************************************
    // Input keepers
    // ****************************************
    // Hold is combinational so the sampling edge of the request already blocks
    assign kif.hold = sleep_active;
    assign kif.d = {io_i, in_pin};

    pdh_keeper #(.W(NK)) u_keep (
        .clk(clk),
        .rst(rst),
        .kp(kif.keeper)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        r_nxt = r_r;
        // Frozen values follow the core only while awake
        if (!sleep_active) begin
            r_nxt.pad_o = core_out;
            r_nxt.pad_oe = core_oe;
            r_nxt.mc_fb = sleep_mc_d;
        end
        case (r_r.st)
            PDH_RUN: begin
                if (sleep_active) begin
                    r_nxt.st = PDH_SLEEP;
                    r_nxt.run = 1'b0;
                    r_nxt.settled = 1'b0;
                end
            end
            PDH_SLEEP: begin
                // Only the sleep pin can end this state
                if (!sleep_active) begin
                    r_nxt.st = PDH_SETTLE;
                    r_nxt.run = 1'b1;
                    r_nxt.cnt = '0;
                end
            end
            PDH_SETTLE: begin
                if (sleep_active) begin
                    r_nxt.st = PDH_SLEEP;
                    r_nxt.run = 1'b0;
                end else if (r_r.cnt == CNT_LAST) begin
                    r_nxt.st = PDH_RUN;
                    r_nxt.settled = 1'b1;
                end else begin
                    r_nxt.cnt = r_r.cnt + CNT_ONE;
                end
            end
            default: begin
                r_nxt.st = PDH_RUN;
                r_nxt.run = RST_RUN;
            end
        endcase
        // Keepers drive only pins whose outputs are off, never fighting a driver
        r_nxt.keep_oe = (r_nxt.st == PDH_SLEEP) ? ~r_nxt.pad_oe : '0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_r.st <= PDH_RUN;
            r_r.cnt <= '0;
            r_r.run <= RST_RUN;
            r_r.settled <= RST_SETTLED;
            r_r.pad_o <= '0;
            r_r.pad_oe <= '0;
            r_r.keep_oe <= '0;
            r_r.mc_fb <= RST_BIT;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign io_o = r_r.pad_o;
    assign io_oe = r_r.pad_oe;
    assign io_keep_o = kif.q[NK-1:N_IN];
    assign io_keep_oe = r_r.keep_oe;
    assign core_in = kif.q;
    assign core_run = r_r.run;
    assign sleep_mc_fb = r_r.mc_fb;
    assign out_settled = r_r.settled;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_sleep_seen;
        sleep_active ##1 sleep_active;
    endsequence

    sequence s_wake;
        (r_r.st == PDH_SLEEP) && !sleep_request_pin;
    endsequence

    property p_disabled_ignored;
        @(posedge clk) disable iff (rst)
        (!PD_ENABLE && core_run) |=> core_run;
    endproperty
    a_disabled_ignored: assert property (p_disabled_ignored) else $error("sleep acted while disabled");

    property p_enter;
        @(posedge clk) disable iff (rst)
        sleep_active |=> !core_run && !out_settled;
    endproperty
    a_enter: assert property (p_enter) else $error("core not frozen after sleep request");

    property p_stay;
        @(posedge clk) disable iff (rst)
        (!core_run && sleep_request_pin) |=> !core_run;
    endproperty
    a_stay: assert property (p_stay) else $error("left sleep while pin high");

    property p_out_hold;
        @(posedge clk) disable iff (rst)
        s_sleep_seen |=> $stable(io_o) && $stable(sleep_mc_fb);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output changed during sleep");

    property p_hiz_hold;
        @(posedge clk) disable iff (rst)
        sleep_active |=> (io_oe == $past(io_oe)) && ((io_keep_oe & io_oe) == '0);
    endproperty
    a_hiz_hold: assert property (p_hiz_hold) else $error("enable changed during sleep");

    property p_in_block;
        @(posedge clk) disable iff (rst)
        sleep_active |=> $stable(core_in);
    endproperty
    a_in_block: assert property (p_in_block) else $error("input reached core during sleep");

    property p_keeper_on;
        @(posedge clk) disable iff (rst)
        s_sleep_seen |-> io_keep_oe == ~io_oe;
    endproperty
    a_keeper_on: assert property (p_keeper_on) else $error("keeper not driving idle pin");

    property p_mc_feedback;
        @(posedge clk) disable iff (rst)
        // Reset in the antecedent: the capture edge that releases reset still loads zero
        (!rst && !sleep_active) |=> sleep_mc_fb == $past(sleep_mc_d);
    endproperty
    a_mc_feedback: assert property (p_mc_feedback) else $error("macrocell feedback lost");

    property p_wake;
        @(posedge clk) disable iff (rst)
        s_wake |=> core_run ##[1:SETTLE_LIM] (out_settled || sleep_request_pin);
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not resume in time");
endmodule

// File: testbench/pdh_sleep_partner.sv
// Far-side model: system logic that drives the sleep request pin
`timescale 1ns/100ps
module pdh_sleep_partner
    import pdh_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request from the bench, pin to the device
    input wire logic want_sleep,
    output logic sleep_request_pin,
    output logic may_rely
);
    localparam int WAIT_CYC = SETTLE_NS / CLK_PERIOD_NS;
    int cnt_r;
    // Only the pin carries the request; nothing else of the device sees it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_request_pin <= 1'b0;
            cnt_r <= WAIT_CYC + 1;
        end else begin
            sleep_request_pin <= want_sleep;
            if (sleep_request_pin) begin
                cnt_r <= 0;
            end else if (cnt_r <= WAIT_CYC) begin
                cnt_r <= cnt_r + 1;
            end
        end
    end
    // Outputs are trusted only after a full microsecond awake
    assign may_rely = !sleep_request_pin && cnt_r > WAIT_CYC;
endmodule

// File: testbench/pdh_top_tb.sv
// Self-checking bench for the power-down hold block
`timescale 1ns/100ps
module pdh_top_tb;
    import pdh_pkg::*;
    localparam int NI = 4;
    localparam int NO = 32;
    logic clk = 1'b0;
    logic rst;
    logic want_sleep = 1'b0;
    logic sleep_request_pin, may_rely, sleep_mc_d = 1'b0;
    logic [NI-1:0] in_pin = '0;
    logic [NO-1:0] io_i = '0, core_out = '0, core_oe = '0;
    logic [NO-1:0] io_o, io_oe, io_keep_o, io_keep_oe, io_o2, m_o, m_oe, m_koe, m_o2;
    logic [NI+NO-1:0] core_in, m_in;
    logic core_run, sleep_mc_fb, out_settled, core_run2, settled2;
    logic m_run, m_fb, m_set, sl;
    int cnt, num_errors = 0, checks_done = 0, cycles = 0;
    int seed = 32'h7609;

    pdh_sleep_partner partner (.clk(clk), .rst(rst), .want_sleep(want_sleep),
        .sleep_request_pin(sleep_request_pin), .may_rely(may_rely));
    pdh_top #(.N_IN(NI), .N_IO(NO), .PD_ENABLE(1'b1)) dut (.clk(clk), .rst(rst),
        .sleep_request_pin(sleep_request_pin), .in_pin(in_pin), .io_i(io_i),
        .io_o(io_o), .io_oe(io_oe), .io_keep_o(io_keep_o), .io_keep_oe(io_keep_oe),
        .core_out(core_out), .core_oe(core_oe), .sleep_mc_d(sleep_mc_d),
        .core_in(core_in), .core_run(core_run), .sleep_mc_fb(sleep_mc_fb),
        .out_settled(out_settled));
    pdh_top #(.N_IN(NI), .N_IO(NO), .PD_ENABLE(1'b0)) dut_off (.clk(clk), .rst(rst),
        .sleep_request_pin(sleep_request_pin), .in_pin(in_pin), .io_i(io_i),
        .io_o(io_o2), .io_oe(), .io_keep_o(), .io_keep_oe(),
        .core_out(core_out), .core_oe(core_oe), .sleep_mc_d(sleep_mc_d),
        .core_in(), .core_run(core_run2), .sleep_mc_fb(),
        .out_settled(settled2));

    always #5 clk = ~clk;

    // ****************************************
    // Reference model
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            m_o = '0;
            m_oe = '0;
            m_koe = '0;
            m_in = '0;
            m_o2 = '0;
            m_run = 1'b1;
            m_fb = 1'b0;
            m_set = 1'b1;
            cnt = 0;
        end else begin
            sl = sleep_request_pin;
            m_o2 = core_out;
            if (!sl) begin
                m_o = core_out;
                m_oe = core_oe;
                m_in = {io_i, in_pin};
                m_fb = sleep_mc_d;
            end
            m_run = !sl;
            m_koe = sl ? ~m_oe : '0;
            if (sl) begin
                m_set = 1'b0;
                cnt = 0;
            end else if (!m_set) begin
                cnt++;
                m_set = (cnt == SETTLE_CYC + 1);
            end
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Comparison on settled outputs
    // ****************************************
    always @(negedge clk) begin
        check("io_o", io_o, m_o);
        check("io_oe", io_oe, m_oe);
        check("io_keep_oe", io_keep_oe, m_koe);
        check("core_in", core_in, m_in);
        check("io_keep_o", io_keep_o, m_in[NI+NO-1:NI]);
        check("core_run", core_run, m_run);
        check("sleep_mc_fb", sleep_mc_fb, m_fb);
        check("out_settled", out_settled, m_set);
        if (may_rely === 1'b1) begin
            check("settled_when_relied", out_settled, 1'b1);
        end
        check("off_io_o", io_o2, m_o2);
        check("off_core_run", core_run2, 1'b1);
        check("off_settled", settled2, 1'b1);
        cycles++;
        // Cuts a hang well past the expected few thousand cycles
        if (cycles > 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    // Fresh random pins every cycle, so freezing is seen against moving inputs
    always @(posedge clk) begin
        core_out <= $random(seed);
        core_oe <= $random(seed);
        io_i <= $random(seed);
        in_pin <= NI'($random(seed));
        sleep_mc_d <= 1'($random(seed));
    end

    // ****************************************
    // Sleep episodes of 1 to 8 cycles, each followed by a full wake or a re-entry inside the settle window
    // ****************************************
    initial begin
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            want_sleep <= 1'b1;
            repeat (($random(seed) & 7) + 1) @(posedge clk);
            want_sleep <= 1'b0;
            repeat (($random(seed) & 8'h7f) + 1) @(posedge clk);
        end
        repeat (120) @(posedge clk);
        give_verdict();
    end
endmodule
